/* File: hw/dac_link_pkg.sv */
// shared constants for the serial input latch link and its two ends
package dac_link_pkg;
	// word layout: address byte above a 16-bit data word
	localparam int WORD_BITS = 24;
	localparam int ADDR_BITS = 8;
	localparam int DATA_BITS = 16;
	localparam int ADDR_LSB = DATA_BITS;
	localparam int DATA_LSB = 0;

	// address byte functions
	localparam logic [ADDR_BITS-1:0] ADDR_NOP = 8'h00;
	localparam logic [ADDR_BITS-1:0] ADDR_CODE = 8'h01;
	localparam logic [ADDR_BITS-1:0] ADDR_CONFIG = 8'h55;

	// register reset values
	localparam logic [DATA_BITS-1:0] CODE_RESET = 16'h0000;
	localparam logic [DATA_BITS-1:0] CONFIG_RESET = 16'h0000;

	// converter core: top bits drive segment switches, the rest the ladder
	localparam int RESOLUTION = 16;
	localparam int SEG_CODE_BITS = 4;
	localparam int SEG_COUNT = 15;

	// edge bookkeeping width; the difference of marks wraps after 65536 edges without a strobe
	localparam int EDGE_CNT_BITS = 16;

	// host timing: serial clock derived from the system clock
	localparam int CLK_MHZ = 100;
	localparam int SCLK_MAX_MHZ = 30;
	// half period rounds up so the serial clock never exceeds its ceiling
	localparam int SCLK_HALF_CYCLES = (CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
	localparam int LATCH_HIGH_CYCLES = 2;
	localparam int DIV_BITS = 4;
	localparam int BIT_CNT_BITS = 5;
endpackage

/* File: hw/dac_link_if.sv */
// three-wire write link between host and converter input port
`timescale 1ns/1ps
interface dac_link_if;
	logic sclk;
	logic serial_data_in;
	logic load_strobe;

	modport device (
		input sclk,
		input serial_data_in,
		input load_strobe
	);

	modport host (
		output sclk,
		output serial_data_in,
		output load_strobe
	);
endinterface

/* File: hw/seg_decoder.sv */
// thermometer decoder from the top code bits to segment switch controls
`timescale 1ns/1ps
module seg_decoder #(
	parameter int CODE_BITS = dac_link_pkg::SEG_CODE_BITS,
	parameter int SEGMENTS = dac_link_pkg::SEG_COUNT
) (
	input wire logic [CODE_BITS-1:0] code,
	output logic [SEGMENTS-1:0] segments
);
	// segment i closes when the code exceeds i, giving a unary fill
	genvar i;
	generate
		for (i = 0; i < SEGMENTS; i++) begin : g_seg
			assign segments[i] = (code > CODE_BITS'(i));
		end
	endgenerate
endmodule

/* File: hw/dac_device.sv */
// converter end: serial shift register, strobe capture and register update
`timescale 1ns/1ps
module dac_device #(
	parameter int RESOLUTION = dac_link_pkg::RESOLUTION
) (
	input wire logic clk,
	input wire logic rst,
	dac_link_if.device link,
	output logic [dac_link_pkg::DATA_BITS-1:0] code_reg,
	output logic [dac_link_pkg::DATA_BITS-1:0] config_reg,
	output logic [dac_link_pkg::SEG_COUNT-1:0] segment_switches,
	output logic [RESOLUTION-dac_link_pkg::SEG_CODE_BITS-1:0] ladder_switches,
	output logic output_update,
	output logic word_rejected
);
	localparam int LADDER_BITS = RESOLUTION - dac_link_pkg::SEG_CODE_BITS;
	localparam int LADDER_MSB = dac_link_pkg::DATA_BITS - dac_link_pkg::SEG_CODE_BITS - 1;
	localparam int SEG_LSB = dac_link_pkg::DATA_BITS - dac_link_pkg::SEG_CODE_BITS;
	localparam logic [dac_link_pkg::EDGE_CNT_BITS-1:0] EDGES_PER_WORD =
		dac_link_pkg::EDGE_CNT_BITS'(dac_link_pkg::WORD_BITS);

	// three clock domains meet in this module: the serial clock shifts,
	// the strobe captures and the system clock applies the word.
	// only the toggle bit crosses into the system clock, through two
	// flip-flops; the captured word and its edge count are held still
	// until the next strobe, so they are read only once they are settled.
	// limitation: the strobe reads the shift register and the edge count
	// with no handshake, so the host must keep the serial clock quiet
	// around every strobe rise; a clash there can capture a torn word.
	// a 12-bit part simply ignores the lowest data bits of each word.

	// link clock domain: shift register and free-running edge count
	logic [dac_link_pkg::WORD_BITS-1:0] shift_reg;
	logic [dac_link_pkg::EDGE_CNT_BITS-1:0] edge_cnt;

	// strobe domain: captured word and how many edges came with it
	logic [dac_link_pkg::WORD_BITS-1:0] held_word;
	logic [dac_link_pkg::EDGE_CNT_BITS-1:0] edge_mark;
	logic [dac_link_pkg::EDGE_CNT_BITS-1:0] held_edges;
	logic load_toggle;

	// system clock domain: toggle synchroniser and apply logic
	logic toggle_meta;
	logic toggle_sync;
	logic toggle_seen;

	// shifting ignores the strobe entirely, so a word can be clocked in
	// while the previous one is still being captured
	// reset clears the count so the first word is measured from reset
	always_ff @(posedge link.sclk or posedge rst) begin
		if (rst) begin
			shift_reg <= '0;
			edge_cnt <= '0;
		end else begin
			shift_reg <= {shift_reg[dac_link_pkg::WORD_BITS-2:0], link.serial_data_in};
			edge_cnt <= edge_cnt + 1'b1;
		end
	end

	// the strobe edge is the only event that marks a word boundary, so the
	// edge count is cleared only by reset; the difference of two marks is used instead
	// the difference survives a wrap of the count between two strobes
	wire [dac_link_pkg::EDGE_CNT_BITS-1:0] edges_since_mark = edge_cnt - edge_mark;

	// capture on every strobe rise, valid or not; the clock is stopped or
	// quiet around the strobe when the host keeps its timing
	// taking the mark here starts the count of the next word at this strobe
	always_ff @(posedge link.load_strobe or posedge rst) begin
		if (rst) begin
			held_word <= '0;
			edge_mark <= '0;
			held_edges <= '0;
			load_toggle <= 1'b0;
		end else begin
			held_word <= shift_reg;
			held_edges <= edges_since_mark;
			edge_mark <= edge_cnt;
			load_toggle <= ~load_toggle;
		end
	end

	// toggle crossing into the system clock; held_word stays put until the
	// next strobe, which the host spaces well beyond the sync delay
	// the third flop only remembers the toggle already acted on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			toggle_meta <= 1'b0;
			toggle_sync <= 1'b0;
			toggle_seen <= 1'b0;
		end else begin
			toggle_meta <= load_toggle;
			toggle_sync <= toggle_meta;
			toggle_seen <= toggle_sync;
		end
	end

	// one compare shared by the code and configuration loads
	function automatic logic addr_hit(
		input logic [dac_link_pkg::ADDR_BITS-1:0] addr,
		input logic [dac_link_pkg::ADDR_BITS-1:0] target
	);
		return addr == target;
	endfunction

	// a new capture shows as a change of the synchronised toggle
	wire load_event = toggle_sync ^ toggle_seen;

	// address and data fields of the captured word
	wire [dac_link_pkg::ADDR_BITS-1:0] word_addr =
		held_word[dac_link_pkg::WORD_BITS-1:dac_link_pkg::ADDR_LSB];
	wire [dac_link_pkg::DATA_BITS-1:0] word_data =
		held_word[dac_link_pkg::ADDR_LSB-1:dac_link_pkg::DATA_LSB];

	// a word counts only with exactly one word of edges before its strobe;
	// short and long words are both captured but never applied
	wire count_short = held_edges < EDGES_PER_WORD;
	wire count_long = held_edges > EDGES_PER_WORD;
	wire word_ok = !count_short && !count_long;

	// qualified loads; any other address falls through both compares
	wire hit_code =
		load_event && word_ok && addr_hit(word_addr, dac_link_pkg::ADDR_CODE);
	wire hit_config =
		load_event && word_ok && addr_hit(word_addr, dac_link_pkg::ADDR_CONFIG);
	wire bad_word = load_event && !word_ok;

	// segment pattern for the incoming code, registered only on a code load
	logic [dac_link_pkg::SEG_COUNT-1:0] next_segments;
	seg_decoder #(
		.CODE_BITS(dac_link_pkg::SEG_CODE_BITS),
		.SEGMENTS(dac_link_pkg::SEG_COUNT)
	) u_seg_decoder (
		.code(word_data[dac_link_pkg::DATA_BITS-1:SEG_LSB]),
		.segments(next_segments)
	);

	// ladder takes the bits under the segment field; a 12-bit part drops
	// the four lowest data bits
	wire [LADDER_BITS-1:0] next_ladder = word_data[LADDER_MSB -: LADDER_BITS];

	// output code register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code_reg <= dac_link_pkg::CODE_RESET;
		end else if (hit_code) begin
			code_reg <= word_data;
		end
	end

	// switch controls load on the same edge as the code register, so the
	// output never shows a code that is only partly applied
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			segment_switches <= '0;
			ladder_switches <= '0;
		end else if (hit_code) begin
			segment_switches <= next_segments;
			ladder_switches <= next_ladder;
		end
	end

	// configuration register
	// its fields act only on the analog side, so nothing here reads it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_reg <= dac_link_pkg::CONFIG_RESET;
		end else if (hit_config) begin
			config_reg <= word_data;
		end
	end

	// one-cycle update flag; a nop or unknown address never raises it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			output_update <= 1'b0;
		end else begin
			output_update <= hit_code;
		end
	end

	// one-cycle reject flag for a word with the wrong edge count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_rejected <= 1'b0;
		end else begin
			word_rejected <= bad_word;
		end
	end
endmodule

/* File: hw/dac_host.sv */
// host end: serialises address and data words and pulses the load strobe
`timescale 1ns/1ps
module dac_host #(
	parameter int HALF_CYCLES = dac_link_pkg::SCLK_HALF_CYCLES,
	parameter int LATCH_CYCLES = dac_link_pkg::LATCH_HIGH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	dac_link_if.host link,
	input wire logic start,
	input wire logic [dac_link_pkg::ADDR_BITS-1:0] addr,
	input wire logic [dac_link_pkg::DATA_BITS-1:0] data,
	output logic ready,
	output logic done
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_LATCH = 2'b10,
		ST_GAP = 2'b11
	} host_state_t;

	localparam logic [dac_link_pkg::DIV_BITS-1:0] HALF_LAST =
		dac_link_pkg::DIV_BITS'(HALF_CYCLES - 1);
	localparam logic [dac_link_pkg::DIV_BITS-1:0] LATCH_LAST =
		dac_link_pkg::DIV_BITS'(LATCH_CYCLES - 1);
	localparam logic [dac_link_pkg::BIT_CNT_BITS-1:0] BIT_LAST =
		dac_link_pkg::BIT_CNT_BITS'(dac_link_pkg::WORD_BITS - 1);

	host_state_t state;
	logic [dac_link_pkg::DIV_BITS-1:0] div;
	logic [dac_link_pkg::BIT_CNT_BITS-1:0] bit_cnt;
	logic [dac_link_pkg::WORD_BITS-1:0] tx_word;
	logic sclk_q;
	logic serial_data_in_q;
	logic latch_q;

	wire half_end = (div == HALF_LAST);
	wire latch_end = (div == LATCH_LAST);
	wire last_bit = (bit_cnt == BIT_LAST);
	wire [dac_link_pkg::WORD_BITS-1:0] new_word = {addr, data};

	assign link.sclk = sclk_q;
	assign link.serial_data_in = serial_data_in_q;
	assign link.load_strobe = latch_q;

	// gated burst: exactly one word of clock edges, clock idles low, data
	// changes only while the clock is low; divider keeps it under the ceiling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			div <= '0;
			bit_cnt <= '0;
			tx_word <= '0;
			sclk_q <= 1'b0;
			serial_data_in_q <= 1'b0;
			latch_q <= 1'b0;
			ready <= 1'b1;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				ST_IDLE: begin
					div <= '0;
					if (start) begin
						tx_word <= {new_word[dac_link_pkg::WORD_BITS-2:0], 1'b0};
						serial_data_in_q <= new_word[dac_link_pkg::WORD_BITS-1];
						bit_cnt <= '0;
						ready <= 1'b0;
						state <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					div <= half_end ? '0 : div + 1'b1;
					if (half_end && !sclk_q) begin
						sclk_q <= 1'b1;
					end else if (half_end) begin
						sclk_q <= 1'b0;
						serial_data_in_q <= tx_word[dac_link_pkg::WORD_BITS-1];
						tx_word <= {tx_word[dac_link_pkg::WORD_BITS-2:0], 1'b0};
						bit_cnt <= bit_cnt + 1'b1;
						if (last_bit) begin
							state <= ST_LATCH;
						end
					end
				end
				ST_LATCH: begin
					latch_q <= 1'b1;
					div <= latch_end ? '0 : div + 1'b1;
					if (latch_end) begin
						state <= ST_GAP;
					end
				end
				ST_GAP: begin
					latch_q <= 1'b0;
					div <= half_end ? '0 : div + 1'b1;
					if (half_end) begin
						ready <= 1'b1;
						done <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

/* File: test/dac_link_props.sv */
// concurrent checks on the joined host and device link
`timescale 1ns/1ps
module dac_link_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic serial_data_in,
	input wire logic load_strobe,
	input wire logic start,
	input wire logic ready,
	input wire logic done,
	input wire logic output_update,
	input wire logic word_rejected,
	input wire logic [dac_link_pkg::DATA_BITS-1:0] code_reg,
	input wire logic [dac_link_pkg::DATA_BITS-1:0] config_reg
);
	logic sclk_q;
	logic strobe_q;
	logic [7:0] edges;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// serial clock rises since the last strobe rise; a same-cycle clash would drop one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			strobe_q <= 1'b0;
			edges <= 8'h00;
		end else begin
			sclk_q <= sclk;
			strobe_q <= load_strobe;
			edges <= (load_strobe && !strobe_q) ? 8'h00 : edges + 8'(sclk && !sclk_q);
		end
	end
	sequence strobe_s;
		!sclk ##0 load_strobe [*2] ##1 !load_strobe;
	endsequence
	sequence word_s;
		##[90:110] done;
	endsequence
	sclk_rate_a: assert property ($changed(sclk) |=> $stable(sclk))
		else $error("serial clock half period too short");
	data_setup_a: assert property ($rose(sclk) |-> $stable(serial_data_in))
		else $error("serial data moved at the sampling edge");
	edge_count_a: assert property ($rose(load_strobe) |-> edges == 8'h18)
		else $error("strobe rose after a wrong number of clock rises");
	strobe_pulse_a: assert property ($rose(load_strobe) |-> strobe_s)
		else $error("strobe pulse shape wrong");
	frame_time_a: assert property (start && ready |-> word_s)
		else $error("transfer did not complete in time");
	no_reject_a: assert property (!word_rejected)
		else $error("well-formed word was rejected");
	code_cause_a: assert property (!$stable(code_reg) |-> output_update)
		else $error("code changed without an update pulse");
	config_only_a: assert property (!$stable(config_reg) |-> $stable(code_reg))
		else $error("config load disturbed the code");
	update_cause_a: assert property (output_update |-> $past(load_strobe, 3))
		else $error("update pulse without a strobe three cycles before");
endmodule

/* File: test/testbench.sv */
// bench: host and device joined, and a rule-breaking driver on a second link
`timescale 1ns/1ps
module testbench;
	logic clk, rst, start, ready, done, output_update, word_rejected, rej_b;
	logic [7:0] addr;
	logic [15:0] data, code_reg, config_reg, code_b, code_m, config_m, rnd;
	logic [14:0] segment_switches;
	logic [11:0] ladder_switches;
	logic [23:0] sh;
	logic [23:0] wire_q[$];
	logic [15:0] upd_q[$];
	int fail_count, samples_checked, rej_cnt, k;
	logic [7:0] addr_tab[6] = '{8'h01, 8'h55, 8'h00, 8'h02, 8'h56, 8'hff};
	logic [24:0] raw_w[4] = '{25'h0011234, 25'h101abcd, 25'h001c3a5, 25'h0077777};
	int raw_n[4] = '{23, 25, 24, 24};
	logic [15:0] raw_code[4] = '{16'h0000, 16'h0000, 16'hc3a5, 16'hc3a5};
	int raw_rej[4] = '{1, 2, 2, 2};
	dac_link_if lnk();
	dac_link_if lnk_b();
	dac_host i_dac_host(.clk(clk), .rst(rst), .link(lnk), .start(start), .addr(addr),
		.data(data), .ready(ready), .done(done));
	dac_device i_dac_device(.clk(clk), .rst(rst), .link(lnk), .code_reg(code_reg),
		.config_reg(config_reg), .segment_switches(segment_switches),
		.ladder_switches(ladder_switches), .output_update(output_update),
		.word_rejected(word_rejected));
	dac_device i_dac_device_b(.clk(clk), .rst(rst), .link(lnk_b), .code_reg(code_b),
		.config_reg(), .segment_switches(), .ladder_switches(), .output_update(),
		.word_rejected(rej_b));
	dac_link_props i_props(.clk(clk), .rst(rst), .sclk(lnk.sclk),
		.serial_data_in(lnk.serial_data_in), .load_strobe(lnk.load_strobe), .start(start),
		.ready(ready), .done(done), .output_update(output_update),
		.word_rejected(word_rejected), .code_reg(code_reg), .config_reg(config_reg));
	always #5 clk = ~clk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [14:0] therm(input logic [3:0] t);
		for (int i = 0; i < 15; i++) therm[i] = (t > i);
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one host transfer; notes go into the queues before the link moves
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		start = 1'b1;
		addr = a;
		data = d;
		wire_q.push_back({a, d});
		if (a == dac_link_pkg::ADDR_CODE) begin
			upd_q.push_back(d);
			code_m = d;
		end
		if (a == dac_link_pkg::ADDR_CONFIG) config_m = d;
		@(negedge clk) start = 1'b0;
		check("busy", 1'b0, ready);
		for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk);
		check("done", 1'b1, done);
		check("ready", 1'b1, ready);
		repeat (4) @(negedge clk);
		check("code", code_m, code_reg);
		check("config", config_m, config_reg);
		check("segments", therm(code_m[15:12]), segment_switches);
		check("ladder", code_m[11:0], ladder_switches);
	endtask
	// gated 48 ns burst; strobe stays high while shifting all but the first word so capture must not depend on it
	task automatic raw(input logic [24:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			lnk_b.serial_data_in = w[i];
			#12 lnk_b.sclk = 1'b1;
			#24 lnk_b.sclk = 1'b0;
			#12;
		end
		lnk_b.serial_data_in = ~w[0];
		lnk_b.load_strobe = 1'b0;
		#60 lnk_b.load_strobe = 1'b1;
		#150;
	endtask
	// rebuild the word seen on the wire and match it against the oldest note
	always @(posedge lnk.sclk) sh = {sh[22:0], lnk.serial_data_in};
	always @(posedge lnk.load_strobe) check("wire word", wire_q.size() ? wire_q.pop_front() : 'x, sh);
	// each update pulse consumes one note
	always @(negedge clk) if (output_update === 1'b1) check("update", upd_q.size() ? upd_q.pop_front() : 'x, code_reg);
	// counted away from the launching edge so the pulse has settled
	always @(negedge clk) if (rej_b === 1'b1) rej_cnt++;
	// watchdog: the whole run needs well under 100 us
	initial begin
		#100000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		addr = 8'h00;
		data = 16'h0000;
		lnk_b.sclk = 1'b0;
		lnk_b.serial_data_in = 1'b0;
		lnk_b.load_strobe = 1'b0;
		code_m = dac_link_pkg::CODE_RESET;
		config_m = dac_link_pkg::CONFIG_RESET;
		rnd = 16'h4df8;
		repeat (4) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr_next(rnd);
			write(addr_tab[i % 6], (i == 0) ? 16'hffff : (i == 6) ? 16'h0000 : rnd);
		end
		#3;
		for (int i = 0; i < 4; i++) begin
			raw(raw_w[i], raw_n[i]);
			check("far code", raw_code[i], code_b);
			check("rejects", raw_rej[i], rej_cnt);
		end
		check("notes left", 0, wire_q.size() + upd_q.size());
		tally_and_finish();
	end
endmodule
